// File: design/hbr_pkg.sv
// ==========================================
// hub routing and configuration constants
package hbr_pkg;
  localparam int NPORTS        = 4;
  localparam int CLK_PERIOD_NS = 50;
  localparam int STRAP_TIME_US = 1000;
  localparam int STRAP_CYC     = (STRAP_TIME_US * 1000) / CLK_PERIOD_NS;

  // ==========================================
  // register byte addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_PWR    = 8'h04;
  localparam logic [7:0] A_LEDMAN = 8'h08;
  localparam logic [7:0] A_STAT   = 8'h0c;
  localparam logic [7:0] A_DIDX   = 8'h10;
  localparam logic [7:0] A_DDATA  = 8'h14;
  localparam logic [7:0] A_IDS    = 8'h18;
  localparam logic [7:0] A_PCFG   = 8'h1c;
  localparam logic [7:0] A_EPINFO = 8'h20;

  // ==========================================
  // field positions
  localparam int CT_LEDMAN = 0;
  localparam int ST_GANG   = 0;
  localparam int ST_SELF   = 1;
  localparam int ST_STRAP  = 2;
  localparam int ST_HS     = 3;
  localparam int ST_SUSP   = 4;
  localparam int ST_EEV    = 5;
  localparam int ST_CONN   = 8;
  localparam int ST_OC     = 12;
  localparam int ST_TT     = 16;
  localparam int EP1_POS   = 8;
  localparam int SY_GANG   = 0;
  localparam int SY_SELF   = 1;
  localparam int SY_OC     = 2;
  localparam int SYNC_W    = 2 + NPORTS;

  // ==========================================
  // hub class descriptor bytes
  localparam logic [3:0] DI_LEN   = 4'h0;
  localparam logic [3:0] DI_TYPE  = 4'h1;
  localparam logic [3:0] DI_NBR   = 4'h2;
  localparam logic [3:0] DI_CHLO  = 4'h3;
  localparam logic [3:0] DI_CHHI  = 4'h4;
  localparam logic [3:0] DI_P2PG  = 4'h5;
  localparam logic [3:0] DI_CURR  = 4'h6;
  localparam logic [3:0] DI_REMOV = 4'h7;
  localparam logic [3:0] DI_PMASK = 4'h8;
  localparam logic [7:0] D_LEN       = 8'h09;
  localparam logic [7:0] D_TYPE      = 8'h29;
  localparam logic [7:0] D_NBR       = 8'h04;
  localparam logic [7:0] D_CHAR_IND  = 8'h89;
  localparam logic [7:0] D_CHAR_GANG = 8'h80;
  localparam logic [7:0] D_CHAR_HI   = 8'h00;
  localparam logic [7:0] D_P2PG      = 8'h32;
  localparam logic [7:0] D_CURR      = 8'h64;
  localparam logic [7:0] D_REMOV     = 8'h00;
  localparam logic [7:0] D_PMASK     = 8'hff;
  localparam logic [7:0] EP0_MAXPKT  = 8'h40;
  localparam logic [7:0] EP1_MAXPKT  = 8'h01;
  // arbitrary neutral identity defaults
  localparam logic [15:0] ROM_VID = 16'h0001;
  localparam logic [15:0] ROM_PID = 16'h0002;

  // ==========================================
  // types
  typedef enum logic [1:0] {SPD_LS, SPD_FS, SPD_HS} hbr_speed_t;
  typedef enum logic [1:0] {PS_OFF, PS_DISC, PS_CONN, PS_OC} hbr_pstate_t;
  typedef struct packed {
    logic       attach;
    hbr_speed_t speed;
  } hbr_ds_t;
  typedef struct packed {
    logic green;
    logic amber;
  } hbr_led_t;
endpackage : hbr_pkg

// File: design/hbr_port_ctl.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// downstream port controller
module hbr_port_ctl
  import hbr_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     rst_n,
  input  wire logic     cfgEnable,
  input  wire logic     pwrReq,
  input  wire logic     overCur,
  input  wire logic     attach,
  input  wire logic     ledManual,
  input  wire hbr_led_t ledMan,
  output logic          pwrEn,
  output logic          connected,
  output logic          ocFlag,
  output hbr_led_t      led
);
  hbr_pstate_t state_ff, nxt_state;
  logic        pwrEn_ff, conn_ff, oc_ff;
  hbr_led_t    led_ff;

  // ==========================================
  // port state machine
  // port state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PS_OFF:  if (pwrReq && cfgEnable && !overCur) nxt_state = PS_DISC;
      PS_DISC: begin
        if (overCur) nxt_state = PS_OC;
        else if (!pwrReq || !cfgEnable) nxt_state = PS_OFF;
        else if (attach) nxt_state = PS_CONN;
      end
      PS_CONN: begin
        if (overCur) nxt_state = PS_OC;
        else if (!pwrReq || !cfgEnable) nxt_state = PS_OFF;
        else if (!attach) nxt_state = PS_DISC;
      end
      PS_OC:   if (!pwrReq) nxt_state = PS_OFF;
      default: nxt_state = PS_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) state_ff <= PS_OFF;
    else state_ff <= nxt_state;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrEn_ff <= 1'b0;
      conn_ff  <= 1'b0;
      oc_ff    <= 1'b0;
    end else begin
      pwrEn_ff <= (nxt_state == PS_DISC) || (nxt_state == PS_CONN);
      conn_ff  <= (nxt_state == PS_CONN);
      oc_ff    <= (nxt_state == PS_OC);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) led_ff <= '0;
    else if (ledManual) led_ff <= ledMan;
    else begin
      led_ff.green <= (nxt_state == PS_CONN);
      led_ff.amber <= (nxt_state == PS_OC);
    end
  end

  assign pwrEn     = pwrEn_ff;
  assign connected = conn_ff;
  assign ocFlag    = oc_ff;
  assign led       = led_ff;

  // ==========================================
  // checks
  a_oc_power_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    overCur && pwrReq && state_ff != PS_OFF |=> !pwrEn_ff && oc_ff)
    else $error("power stays on under over-current");
  a_led_auto: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ledManual && oc_ff |-> led_ff.amber && !led_ff.green)
    else $error("over-current port not amber");
endmodule : hbr_port_ctl
`default_nettype wire

// File: design/hbr_hub_core.sv
`timescale 1ns/10ps
`default_nettype none
module hbr_hub_core
  import hbr_pkg::*;
#(
  parameter int STRAP_CYCLES = STRAP_CYC
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic [7:0]          regAddr,
  input  wire logic [31:0]         regWrData,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic      [31:0]         regRdData,
  input  wire logic                upChirpOk,
  input  wire logic                upSuspend,
  input  wire logic                upResumeIn,
  input  wire hbr_ds_t [NPORTS-1:0] downstreamPort,
  input  wire logic [NPORTS-1:0]   ttReq,
  input  wire logic [NPORTS-1:0]   ocPin_n,
  input  wire logic                selfPowerStrap,
  input  wire logic                gangStrapSuspendPinIn,
  output logic                     gangStrapSuspendPinOut,
  output logic                     gangStrapSuspendPinOe,
  output logic                     upstreamPullupCtl,
  output logic                     upstreamHs,
  output logic [NPORTS-1:0]        routeTt,
  output logic [NPORTS-1:0]        ttGrant,
  output logic [NPORTS-1:0]        portPwrEn,
  output hbr_led_t [NPORTS-1:0]    portLed,
  output logic                     resumeReq
);
  localparam int CW = $clog2(STRAP_CYCLES + 1);

  if (STRAP_CYCLES < 1 || NPORTS != 4) begin : g_chk
    $error("unsupported strap count or port count");
  end

  // ==========================================
  // functions
  function automatic logic [NPORTS-1:0] lowestOne(input logic [NPORTS-1:0] v);
    logic [NPORTS-1:0] r;
    r = '0;
    for (int i = NPORTS - 1; i >= 0; i--) begin
      if (v[i]) r = NPORTS'(1) << i;
    end
    return r;
  endfunction : lowestOne

  function automatic logic [7:0] descByte(input logic [3:0] idx, input logic gang);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      DI_LEN:   b = D_LEN;
      DI_TYPE:  b = D_TYPE;
      DI_NBR:   b = D_NBR;
      DI_CHLO:  b = gang ? D_CHAR_GANG : D_CHAR_IND;
      DI_CHHI:  b = D_CHAR_HI;
      DI_P2PG:  b = D_P2PG;
      DI_CURR:  b = D_CURR;
      DI_REMOV: b = D_REMOV;
      DI_PMASK: b = D_PMASK;
      default:  b = 8'h00;
    endcase
    return b;
  endfunction : descByte

  // ==========================================
  // pin synchronisers
  logic [SYNC_W-1:0] sy1_ff, sy2_ff, sy3_ff, syStable_ff, syRaw;
  assign syRaw = {~ocPin_n, selfPowerStrap, gangStrapSuspendPinIn};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_ff      <= '0;
      sy2_ff      <= '0;
      sy3_ff      <= '0;
      syStable_ff <= '0;
    end else begin
      sy1_ff      <= syRaw;
      sy2_ff      <= sy1_ff;
      sy3_ff      <= sy2_ff;
      syStable_ff <= (~(sy2_ff ^ sy3_ff) & sy3_ff) | ((sy2_ff ^ sy3_ff) & syStable_ff);
    end
  end

  // ==========================================
  // reset, pull-up and upstream mode
  logic pullup_ff, upHs_ff, susp_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) pullup_ff <= 1'b0;
    else pullup_ff <= 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      upHs_ff <= 1'b0;
      susp_ff <= 1'b0;
    end else begin
      upHs_ff <= upChirpOk;
      susp_ff <= upSuspend;
    end
  end

  // ==========================================
  // strap sampling and shared pin
  logic [CW-1:0] strapCnt_ff;
  logic          strapDone_ff, gang_ff, self_ff, pinOut_ff, pinOe_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strapCnt_ff  <= '0;
      strapDone_ff <= 1'b0;
    end else if (!strapDone_ff) begin
      if (strapCnt_ff == CW'(STRAP_CYCLES - 1)) strapDone_ff <= 1'b1;
      else strapCnt_ff <= strapCnt_ff + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) gang_ff <= 1'b0;
    else if (!strapDone_ff) gang_ff <= syStable_ff[SY_GANG];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) self_ff <= 1'b0;
    else self_ff <= syStable_ff[SY_SELF];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOe_ff  <= 1'b0;
      pinOut_ff <= 1'b0;
    end else begin
      pinOe_ff  <= strapDone_ff;
      pinOut_ff <= strapDone_ff && susp_ff;
    end
  end

  // ==========================================
  // software registers
  logic              ledManual_ff, eeValid_ff;
  logic [NPORTS-1:0] pwrReq_ff, portDis_ff;
  logic [7:0]        ledMan_ff;
  logic [3:0]        descIdx_ff;
  logic [31:0]       eeIds_ff, rdData_ff, nxt_rdData, statWord;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ledManual_ff <= 1'b0;
      pwrReq_ff    <= '0;
      ledMan_ff    <= '0;
      descIdx_ff   <= '0;
    end else if (regWr) begin
      case (regAddr)
        A_CTRL:   ledManual_ff <= regWrData[CT_LEDMAN];
        A_PWR:    pwrReq_ff    <= regWrData[NPORTS-1:0];
        A_LEDMAN: ledMan_ff    <= regWrData[7:0];
        A_DIDX:   descIdx_ff   <= regWrData[3:0];
        default:  ledManual_ff <= ledManual_ff;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eeIds_ff   <= '0;
      eeValid_ff <= 1'b0;
      portDis_ff <= '0;
    end else if (regWr && regAddr == A_IDS) begin
      eeIds_ff   <= regWrData;
      eeValid_ff <= 1'b1;
    end else if (regWr && regAddr == A_PCFG) begin
      portDis_ff <= regWrData[NPORTS-1:0];
    end
  end

  // ==========================================
  // port controllers
  logic [NPORTS-1:0] attachV, hsV, ocV, effOc, effPwr, pwrEnV, connV, ocFlagV;
  logic [NPORTS-1:0] attPrev_ff, ocPrev_ff, route_ff, grant_ff;
  hbr_led_t [NPORTS-1:0] ledV;

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    assign attachV[p] = downstreamPort[p].attach;
    assign hsV[p]     = downstreamPort[p].speed == SPD_HS;
    assign ocV[p]     = syStable_ff[SY_OC + p];
    assign effOc[p]   = gang_ff ? |ocV : ocV[p];
    assign effPwr[p]  = gang_ff ? |pwrReq_ff : pwrReq_ff[p];

    hbr_port_ctl u_port (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .cfgEnable (~portDis_ff[p]),
      .pwrReq    (effPwr[p]),
      .overCur   (effOc[p]),
      .attach    (attachV[p]),
      .ledManual (ledManual_ff),
      .ledMan    (ledMan_ff[2*p +: 2]),
      .pwrEn     (pwrEnV[p]),
      .connected (connV[p]),
      .ocFlag    (ocFlagV[p]),
      .led       (ledV[p])
    );
  end

  // ==========================================
  // routing and shared translator
  // repeater same speed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) route_ff <= '0;
    else route_ff <= {NPORTS{upHs_ff}} & attachV & ~hsV;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) grant_ff <= '0;
    else if (!(|(grant_ff & ttReq & route_ff))) grant_ff <= lowestOne(ttReq & route_ff);
  end

  logic resume_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      attPrev_ff <= '0;
      ocPrev_ff  <= '0;
      resume_ff  <= 1'b0;
    end else begin
      attPrev_ff <= attachV;
      ocPrev_ff  <= ocV;
      resume_ff  <= susp_ff && (upResumeIn || |(attachV ^ attPrev_ff) || |(ocV ^ ocPrev_ff));
    end
  end

  // ==========================================
  // read port
  always_comb begin
    statWord = '0;
    statWord[ST_GANG]  = gang_ff;
    statWord[ST_SELF]  = self_ff;
    statWord[ST_STRAP] = strapDone_ff;
    statWord[ST_HS]    = upHs_ff;
    statWord[ST_SUSP]  = susp_ff;
    statWord[ST_EEV]   = eeValid_ff;
    statWord[ST_CONN +: NPORTS] = connV;
    statWord[ST_OC +: NPORTS]   = ocFlagV;
    statWord[ST_TT +: NPORTS]   = route_ff;
  end

  always_comb begin
    nxt_rdData = '0;
    case (regAddr)
      A_CTRL:   nxt_rdData[CT_LEDMAN] = ledManual_ff;
      A_PWR:    nxt_rdData[NPORTS-1:0] = pwrReq_ff;
      A_LEDMAN: nxt_rdData[7:0] = ledMan_ff;
      A_STAT:   nxt_rdData = statWord;
      A_DIDX:   nxt_rdData[3:0] = descIdx_ff;
      A_DDATA:  nxt_rdData[7:0] = descByte(descIdx_ff, gang_ff);
      A_IDS:    nxt_rdData = eeValid_ff ? eeIds_ff : {ROM_PID, ROM_VID};
      A_PCFG:   nxt_rdData[NPORTS-1:0] = portDis_ff;
      A_EPINFO: nxt_rdData[15:0] = {EP1_MAXPKT, EP0_MAXPKT};
      default:  nxt_rdData = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rdData_ff <= '0;
    else rdData_ff <= regRd ? nxt_rdData : '0;
  end

  assign regRdData              = rdData_ff;
  assign gangStrapSuspendPinOut = pinOut_ff;
  assign gangStrapSuspendPinOe  = pinOe_ff;
  assign upstreamPullupCtl      = pullup_ff;
  assign upstreamHs             = upHs_ff;
  assign routeTt                = route_ff;
  assign ttGrant                = grant_ff;
  assign portPwrEn              = pwrEnV;
  assign portLed                = ledV;
  assign resumeReq              = resume_ff;

  // ==========================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_route_same_speed: assert property (
    upHs_ff && attachV[0] && hsV[0] |=> !route_ff[0])
    else $error("high speed port not on repeater");
  a_route_tt_mixed: assert property (
    upHs_ff && attachV[1] && !hsV[1] |=> route_ff[1])
    else $error("slow port not on translator");
  a_fs_all_repeater: assert property (
    !upHs_ff |=> route_ff == '0)
    else $error("translator used behind full speed host");
  a_hs_upstream: assert property (
    upChirpOk |=> upstreamHs)
    else $error("upstream high speed not taken");
  a_resume_wake: assert property (
    susp_ff && upResumeIn |=> resumeReq)
    else $error("wakeup missed while suspended");
  a_tt_onehot: assert property (
    $onehot0(grant_ff) && ((grant_ff & ~$past(route_ff)) == '0 || $past(grant_ff) == grant_ff))
    else $error("translator granted to several ports");
  a_pullup_reset: assert property (
    $rose(rst_n) |-> !upstreamPullupCtl ##1 upstreamPullupCtl)
    else $error("pull-up active at reset release");
  a_strap_input: assert property (
    !strapDone_ff |-> !gangStrapSuspendPinOe)
    else $error("shared pin driven during strap window");
  a_suspend_flag: assert property (
    strapDone_ff && susp_ff |=> gangStrapSuspendPinOut && gangStrapSuspendPinOe)
    else $error("suspend flag not shown");
  a_desc_chars: assert property (
    regRd && regAddr == A_DDATA && descIdx_ff == DI_CHLO
    |=> regRdData[7:0] == (gang_ff ? D_CHAR_GANG : D_CHAR_IND))
    else $error("wrong hub characteristics byte");
  a_desc_header: assert property (
    regRd && regAddr == A_DDATA && descIdx_ff == DI_TYPE |=> regRdData == 32'h0000_0029)
    else $error("wrong descriptor type byte");
  a_read_one_cycle: assert property (
    !regRd |=> regRdData == '0)
    else $error("read data outside its cycle");

  c_route_tt: cover property (upHs_ff ##1 route_ff != '0);
  c_suspend_flag: cover property (strapDone_ff ##1 gangStrapSuspendPinOut);
  c_resume: cover property (resumeReq);
  c_tt_grant: cover property (grant_ff != '0);
endmodule : hbr_hub_core
`default_nettype wire

// File: testbench/hbr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// upstream host and strap board model
module hbr_host_model
  import hbr_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic is20,
  input  wire logic susp,
  input  wire logic wake,
  input  wire logic pullupOn,
  input  wire logic pinOut,
  input  wire logic pinOe,
  input  wire logic strapHigh,
  output logic      upChirpOk,
  output logic      upSuspend,
  output logic      upResumeIn,
  output logic      pinIn
);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      upChirpOk  <= 1'b0;
      upSuspend  <= 1'b0;
      upResumeIn <= 1'b0;
    end else begin
      upChirpOk  <= is20 & pullupOn;
      upSuspend  <= susp & pullupOn;
      upResumeIn <= wake;
    end
  end
  assign pinIn = pinOe ? pinOut : strapHigh;
endmodule : hbr_host_model
`default_nettype wire

// File: testbench/usb2_hub_routing_and_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// hub core testbench
module usb2_hub_routing_and_config_tb
  import hbr_pkg::*;
;
  logic                 sys_clk = 1'b0;
  logic                 rst_n, regWr, regRd, is20, susp, wake, selfStrap, strapHigh, hit;
  logic [7:0]           regAddr;
  logic [31:0]          regWrData, regRdData, rv;
  hbr_ds_t [NPORTS-1:0] downstream_port;
  hbr_led_t [NPORTS-1:0] portLed;
  logic [NPORTS-1:0]    ttReq, ocPin_n, routeTt, ttGrant, portPwrEn;
  logic                 upChirpOk, upSuspend, upResumeIn, pinIn, pinOut, pinOe;
  logic                 pullupOn, upHs, resumeReq;
  int                   n_mismatch = 0, cmp_count = 0, cycles = 0, seed = 32'h119d;
  logic [7:0]           dExp [10] = '{8'h09, 8'h29, 8'h04, 8'h89, 8'h00,
                                      8'h32, 8'h64, 8'h00, 8'hff, 8'h00};

  always #25 sys_clk = ~sys_clk;

  hbr_hub_core #(.STRAP_CYCLES(8)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .upChirpOk(upChirpOk),
    .upSuspend(upSuspend), .upResumeIn(upResumeIn), .downstreamPort(downstream_port),
    .ttReq(ttReq), .ocPin_n(ocPin_n), .selfPowerStrap(selfStrap),
    .gangStrapSuspendPinIn(pinIn), .gangStrapSuspendPinOut(pinOut),
    .gangStrapSuspendPinOe(pinOe), .upstreamPullupCtl(pullupOn), .upstreamHs(upHs),
    .routeTt(routeTt), .ttGrant(ttGrant), .portPwrEn(portPwrEn), .portLed(portLed),
    .resumeReq(resumeReq));

  hbr_host_model i_host (
    .sys_clk(sys_clk), .rst_n(rst_n), .is20(is20), .susp(susp), .wake(wake),
    .pullupOn(pullupOn), .pinOut(pinOut), .pinOe(pinOe), .strapHigh(strapHigh),
    .upChirpOk(upChirpOk), .upSuspend(upSuspend), .upResumeIn(upResumeIn),
    .pinIn(pinIn));

  // ==========================================
  // expectation helpers
  function automatic logic [3:0] route(logic hs, hbr_ds_t [NPORTS-1:0] d);
    for (int p = 0; p < NPORTS; p++) route[p] = hs & d[p].attach & (d[p].speed != SPD_HS);
  endfunction : route

  function automatic logic [3:0] lowest(logic [3:0] v);
    lowest = v & (~v + 4'h1);
  endfunction : lowest

  // ==========================================
  // bus and check tasks
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    #1;
  endtask : wr

  task automatic rc(logic [7:0] a, logic [31:0] m, logic [31:0] e);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    chk("regRead", e, regRdData & m);
  endtask : rc

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_mismatch++;
      summarize;
    end
  end

  // ==========================================
  // main sequence
  initial begin
    {rst_n, regWr, regRd, is20, susp, wake, selfStrap, strapHigh} = '0;
    regAddr = '0;
    regWrData = '0;
    downstream_port = '0;
    ttReq = '0;
    ocPin_n = '1;
    for (int i = 0; i < 4; i++) begin
      rst_n <= 1'b0;
      strapHigh <= i[0];
      is20 <= i[1];
      susp <= 1'b0;
      downstream_port <= '0;
      cyc(10);
      chk("resetPu", 0, 32'({pullupOn, pinOe}));
      chk("resetOut", 0, 32'({portPwrEn, routeTt, ttGrant, resumeReq}));
      rst_n <= 1'b1;
      cyc(3);
      chk("strapOe", 0, 32'(pinOe));
      cyc(11);
      chk("pinOe", 1, 32'(pinOe));
      chk("pullup", 1, 32'(pullupOn));
      chk("upHs", 32'(i[1]), 32'(upHs));
      rc(A_STAT, 32'h1f, {27'h0, 1'b0, i[1], 1'b1, selfStrap, i[0]});
      dExp[3] = i[0] ? 8'h80 : 8'h89;
      for (int j = 0; j < 10; j++) begin
        wr(A_DIDX, 32'(j));
        rc(A_DDATA, 32'hff, {24'h0, dExp[j]});
      end
      wr(A_EPINFO, 32'h0);
      rc(A_EPINFO, '1, 32'h140);
      rc(A_IDS, '1, 32'h00020001);
      rv = $random(seed);
      wr(A_IDS, rv);
      rc(A_IDS, '1, rv);
      rc(8'hfc, '1, 32'h0);
      repeat (8) begin
        for (int p = 0; p < NPORTS; p++) downstream_port[p] <= {1'($random(seed)), 2'({$random(seed)} % 3)};
        cyc(3);
        chk("routeTt", 32'(route(i[1], downstream_port)), 32'(routeTt));
        ttReq <= '0;
        cyc(2);
        ttReq <= 4'($random(seed));
        cyc(3);
        chk("ttGrant", 32'(lowest(ttReq & route(i[1], downstream_port))), 32'(ttGrant));
      end
      ttReq <= '0;
      downstream_port <= {4{3'b101}};
      wr(A_PCFG, 32'h0);
      wr(A_PWR, 32'hf);
      cyc(6);
      chk("pwrOn", 32'hf, 32'(portPwrEn));
      ocPin_n <= 4'b1110;
      cyc(10);
      chk("pwrOc", i[0] ? 32'h0 : 32'he, 32'(portPwrEn));
      chk("ledAuto", i[0] ? 32'h55 : 32'ha9, 32'(portLed));
      ocPin_n <= 4'hf;
      wr(A_PWR, 32'h0);
      cyc(6);
      chk("pwrOff", 32'h0, 32'(portPwrEn));
      rv = $random(seed);
      wr(A_CTRL, 32'h1);
      wr(A_LEDMAN, rv);
      cyc(3);
      chk("ledMan", {24'h0, rv[7:0]}, 32'(portLed));
      selfStrap <= ~selfStrap;
      cyc(8);
      rc(A_STAT, 32'h2, {30'h0, selfStrap, 1'b0});
      susp <= 1'b1;
      cyc(5);
      chk("suspPin", 1, 32'(pinOut));
      wake <= 1'b1;
      cyc(1);
      wake <= 1'b0;
      hit = 1'b0;
      repeat (6) begin
        cyc(1);
        hit = hit | resumeReq;
      end
      chk("resume", 1, 32'(hit));
    end
    summarize;
  end
endmodule : usb2_hub_routing_and_config_tb
`default_nettype wire
